// ==== hw/main_synth_defines.svh ====
// constants for the main synthesizer control block
// assumes it is included by bare name from every file of the block
`ifndef MAIN_SYNTH_DEFINES_SVH
`define MAIN_SYNTH_DEFINES_SVH

// serial word layout
`define WORD_BITS        24
`define ADDR_MSB         2
`define ADDR_REF_WORD    3'h3
`define ADDR_N_WORD      3'h4
`define ADDR_ACQ_WORD    3'h5
`define ADDR_CFG_WORD    3'h6

// reference/prescaler word fields
`define REF_RESET_BIT    23
`define REF_MODULUS_BIT  22
`define REF_POLARITY_BIT 21
`define REF_GAIN_MSB     20
`define REF_GAIN_LSB     19
`define REF_DIV_MSB      18
`define REF_DIV_LSB      10
`define REF_DEN_MSB      9
`define REF_DEN_LSB      3

// N divider word fields
`define N_PD_BIT         23
`define N_INT_MSB        22
`define N_INT_LSB        10
`define N_NUM_MSB        9
`define N_NUM_LSB        3

// acquisition word fields
`define ACQ_CSR_MSB      22
`define ACQ_CSR_LSB      21
`define ACQ_OM_MSB       20
`define ACQ_OM_LSB       19
`define ACQ_GAIN_MSB     18
`define ACQ_GAIN_LSB     17
`define ACQ_TOC_MSB      16
`define ACQ_TOC_LSB      3

// shared configuration word fields
`define CFG_COMP_EN_BIT  16
`define CFG_PD_SYNC_BIT  8

// reset values: address bits only, everything else cleared
`define REF_WORD_RESET   24'h000003
`define N_WORD_RESET     24'h000004
`define ACQ_WORD_RESET   24'h000005
`define CFG_WORD_RESET   24'h000006

// codes and values
`define OM_FRACTIONAL    2'h1
`define TOC_PIN_FLOAT    14'h0000
`define TOC_PIN_LOW      14'h0001
`define TOC_PIN_FORCE    14'h0002
`define TOC_PIN_HIGH     14'h0003
`define TOC_MIN_COUNT    14'h0004
`define GAIN_FORCED      2'h3
`define DEN_ZERO_VALUE   8'h80
`define GAIN_MA_0        5'h01
`define GAIN_MA_1        5'h04
`define GAIN_MA_2        5'h08
`define GAIN_MA_3        5'h10

`endif

// ==== hw/main_synth_pkg.sv ====
// types shared by the main synthesizer control block
// assumes main_synth_defines.svh is on the include path
`include "main_synth_defines.svh"

package main_synth_pkg;

   // acquisition state, one-hot
   typedef enum logic [1:0] {
      ACQ_IDLE    = 2'b01,
      ACQ_ENGAGED = 2'b10
   } acq_state_t;

   // power state, one-hot
   typedef enum logic [2:0] {
      PWR_UP   = 3'b001,
      PWR_WAIT = 3'b010,
      PWR_DOWN = 3'b100
   } power_state_t;

   // divider settings handed to the counters
   typedef struct packed {
      logic        modulus_large;
      logic        frac_mode;
      logic [1:0]  swallow_count;
      logic [1:0]  mid_count;
      logic [8:0]  high_count;
      logic [12:0] int_division;
      logic [6:0]  frac_numerator;
      logic [7:0]  frac_denominator;
      logic [20:0] n_total;
      logic [16:0] r_total;
   } divider_ctrl_t;

   // charge pump settings
   typedef struct packed {
      logic [1:0] gain;
      logic [4:0] current_ma;
      logic       polarity;
      logic       tristate;
   } pump_ctrl_t;

endpackage

// ==== hw/serial_word_shift.sv ====
// serial control word shifter, runs on the serial clock
// assumes the host shifts msb first and holds the clock still while latch is high
`timescale 1ns/1ps
`default_nettype none
`include "main_synth_defines.svh"

module serial_word_shift #(
   parameter int WIDTH = `WORD_BITS
) (
   // link side
   input  wire logic             ser_clk,
   input  wire logic             ser_data,
   // captured word, stable while the clock is idle
   output logic [WIDTH-1:0]      shift_word
);

   // msb first shift
   // no reset and no power gating, so words load in every power state
   // always shifting
   always_ff @(posedge ser_clk) begin
      shift_word <= {shift_word[WIDTH-2:0], ser_data};
   end

endmodule

`default_nettype wire

// ==== hw/main_synth_divider_control.sv ====
// main synthesizer control: serial word latch, divider, pump, power, acquisition
// assumes the host keeps the serial clock still while latch enable is high,
// and that comparison ticks and pump activity arrive as asynchronous levels
`timescale 1ns/1ps
`default_nettype none
`include "main_synth_defines.svh"

module main_synth_divider_control #(
   parameter int WIDTH = `WORD_BITS
) (
   // core clock and reset
   input  wire logic                  core_clk,
   input  wire logic                  rst,
   // three-wire serial link
   input  wire logic                  ser_clk,
   input  wire logic                  ser_data,
   input  wire logic                  latch_en,
   // analog side status, asynchronous
   input  wire logic                  cmp_tick,
   input  wire logic                  pump_busy,
   input  wire logic                  aux_powered_down,
   // divider and pump control
   output var main_synth_pkg::divider_ctrl_t divider,
   output var main_synth_pkg::pump_ctrl_t    pump,
   output logic                       counter_reset_hold,
   output logic                       synth_power_down,
   output logic                       ref_input_float,
   // acquisition and fractional control
   output logic                       acq_engaged,
   output logic [1:0]                 slip_factor,
   output logic                       frac_comp_enable,
   // acquisition output pin
   output logic                       acq_pin_out,
   output logic                       acq_pin_oe
);

   // word captured in the serial clock domain
   logic [WIDTH-1:0] shift_word;

   serial_word_shift #(
      .WIDTH (WIDTH)
   ) u_shift (
      .ser_clk    (ser_clk),
      .ser_data   (ser_data),
      .shift_word (shift_word)
   );

   // synchroniser stages
   logic le_meta;
   logic le_stable;
   logic le_prev;
   logic tick_meta;
   logic tick_stable;
   logic tick_prev;
   logic busy_meta;
   logic busy_stable;
   logic auxpd_meta;
   logic auxpd_stable;

   // two-flop synchronisers for every asynchronous input
   always_ff @(posedge core_clk) begin
      le_meta      <= latch_en;
      le_stable    <= le_meta;
      tick_meta    <= cmp_tick;
      tick_stable  <= tick_meta;
      busy_meta    <= pump_busy;
      busy_stable  <= busy_meta;
      auxpd_meta   <= aux_powered_down;
      auxpd_stable <= auxpd_meta;
   end

   // edge memories, reset so no false edge after reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         le_prev   <= 1'b0;
         tick_prev <= 1'b0;
      end else begin
         le_prev   <= le_stable;
         tick_prev <= tick_stable;
      end
   end

   // event decode
   wire logic       latch_pulse = le_stable & ~le_prev;
   wire logic       cmp_event   = tick_stable & ~tick_prev;
   wire logic [2:0] word_addr   = shift_word[`ADDR_MSB:0];

   wire logic hit_ref = latch_pulse && (word_addr == `ADDR_REF_WORD);
   wire logic hit_n   = latch_pulse && (word_addr == `ADDR_N_WORD);
   wire logic hit_acq = latch_pulse && (word_addr == `ADDR_ACQ_WORD);
   wire logic hit_cfg = latch_pulse && (word_addr == `ADDR_CFG_WORD);

   // control words
   logic [WIDTH-1:0] main_ref_word;
   logic [WIDTH-1:0] main_n_divider_word;
   logic [WIDTH-1:0] main_acquisition_word;
   logic [WIDTH-1:0] shared_config_word;

   // shift word is frozen while latch is high, so copying it here is a safe crossing
   // latching ignores power state
   always_ff @(posedge core_clk) begin
      if (rst) begin
         main_ref_word         <= `REF_WORD_RESET;
         main_n_divider_word   <= `N_WORD_RESET;
         main_acquisition_word <= `ACQ_WORD_RESET;
         shared_config_word    <= `CFG_WORD_RESET;
      end else begin
         if (hit_ref)
            main_ref_word <= shift_word;
         if (hit_n)
            main_n_divider_word <= shift_word;
         if (hit_acq)
            main_acquisition_word <= shift_word;
         if (hit_cfg)
            shared_config_word <= shift_word;
      end
   end

   // field extraction
   wire logic        main_counter_reset     = main_ref_word[`REF_RESET_BIT];
   wire logic        main_modulus_select    = main_ref_word[`REF_MODULUS_BIT];
   wire logic        main_detector_polarity = main_ref_word[`REF_POLARITY_BIT];
   wire logic [1:0]  main_pump_gain         = main_ref_word[`REF_GAIN_MSB:`REF_GAIN_LSB];
   wire logic [8:0]  main_ref_division      = main_ref_word[`REF_DIV_MSB:`REF_DIV_LSB];
   wire logic [6:0]  main_frac_denominator  = main_ref_word[`REF_DEN_MSB:`REF_DEN_LSB];
   wire logic        main_power_down        = main_n_divider_word[`N_PD_BIT];
   wire logic [12:0] main_int_division      = main_n_divider_word[`N_INT_MSB:`N_INT_LSB];
   wire logic [6:0]  main_frac_numerator    = main_n_divider_word[`N_NUM_MSB:`N_NUM_LSB];
   wire logic [1:0]  main_slip_reduction    = main_acquisition_word[`ACQ_CSR_MSB:`ACQ_CSR_LSB];
   wire logic [1:0]  main_operating_mode    = main_acquisition_word[`ACQ_OM_MSB:`ACQ_OM_LSB];
   wire logic [1:0]  main_acq_pump_gain     = main_acquisition_word[`ACQ_GAIN_MSB:`ACQ_GAIN_LSB];
   wire logic [13:0] main_acq_timeout       = main_acquisition_word[`ACQ_TOC_MSB:`ACQ_TOC_LSB];
   wire logic        frac_compensation_enable = shared_config_word[`CFG_COMP_EN_BIT];
   wire logic        powerdown_sync_select  = shared_config_word[`CFG_PD_SYNC_BIT];

   // only code 1 is fractional; reserved codes fall back to integer
   wire logic frac_mode = (main_operating_mode == `OM_FRACTIONAL);

   wire logic [7:0] den_eff = (main_frac_denominator == 7'h00) ? `DEN_ZERO_VALUE
                                                                : {1'b0, main_frac_denominator};

   // split integer N into counters
   // small prescaler ignores bit 3 of the integer part
   wire logic [1:0] swallow_eff = main_int_division[1:0];
   wire logic [1:0] mid_eff     = main_modulus_select ? main_int_division[3:2]
                                                      : {1'b0, main_int_division[2]};
   wire logic [8:0] high_eff    = main_int_division[12:4];

   // integer mode total is int times denominator plus numerator
   wire logic [20:0] n_product   = 21'(main_int_division) * 21'(den_eff);
   wire logic [20:0] n_int_total = n_product + 21'(main_frac_numerator);
   wire logic [20:0] n_total_eff = frac_mode ? 21'(main_int_division) : n_int_total;

   // integer mode reference division is R times denominator
   wire logic [16:0] r_product = 17'(main_ref_division) * 17'(den_eff);
   wire logic [16:0] r_total_eff = frac_mode ? 17'(main_ref_division) : r_product;

   // acquisition state machine
   main_synth_pkg::acq_state_t acq_state;
   main_synth_pkg::acq_state_t next_acq_state;
   logic [13:0]                acq_count;
   logic [13:0]                next_acq_count;

   // codes 4 and up run the timeout counter
   wire logic timeout_enabled = (main_acq_timeout >= `TOC_MIN_COUNT);
   wire logic last_cycle      = (acq_count == 14'h0001);

   // new N word restarts the count; it uses whatever timeout was last written
   always_comb begin
      next_acq_state = acq_state;
      next_acq_count = acq_count;
      case (acq_state)
         main_synth_pkg::ACQ_IDLE: begin
            if (hit_n && timeout_enabled) begin
               next_acq_state = main_synth_pkg::ACQ_ENGAGED;
               next_acq_count = main_acq_timeout;
            end
         end
         main_synth_pkg::ACQ_ENGAGED: begin
            if (hit_n && timeout_enabled) begin
               next_acq_count = main_acq_timeout;
            end else if (!timeout_enabled) begin
               next_acq_state = main_synth_pkg::ACQ_IDLE;
               next_acq_count = 14'h0000;
            end else if (cmp_event && last_cycle) begin
               next_acq_state = main_synth_pkg::ACQ_IDLE;
               next_acq_count = 14'h0000;
            end else if (cmp_event) begin
               next_acq_count = acq_count - 14'h0001;
            end
         end
         default: begin
            next_acq_state = main_synth_pkg::ACQ_IDLE;
            next_acq_count = 14'h0000;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         acq_state <= main_synth_pkg::ACQ_IDLE;
         acq_count <= 14'h0000;
      end else begin
         acq_state <= next_acq_state;
         acq_count <= next_acq_count;
      end
   end

   wire logic engaged_now = (acq_state == main_synth_pkg::ACQ_ENGAGED);

   // power state machine
   main_synth_pkg::power_state_t pwr_state;
   main_synth_pkg::power_state_t next_pwr_state;

   // clearing the power down bit always wins at once, which is how a single
   // N word write brings the synthesizer back up
   always_comb begin
      next_pwr_state = pwr_state;
      case (pwr_state)
         main_synth_pkg::PWR_UP: begin
            if (main_power_down && powerdown_sync_select)
               next_pwr_state = main_synth_pkg::PWR_WAIT;
            else if (main_power_down)
               next_pwr_state = main_synth_pkg::PWR_DOWN;
         end
         main_synth_pkg::PWR_WAIT: begin
            if (!main_power_down)
               next_pwr_state = main_synth_pkg::PWR_UP;
            else if (!busy_stable || !powerdown_sync_select)
               next_pwr_state = main_synth_pkg::PWR_DOWN;
         end
         main_synth_pkg::PWR_DOWN: begin
            if (!main_power_down)
               next_pwr_state = main_synth_pkg::PWR_UP;
         end
         default: begin
            next_pwr_state = main_synth_pkg::PWR_UP;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (rst)
         pwr_state <= main_synth_pkg::PWR_UP;
      else
         pwr_state <= next_pwr_state;
   end

   wire logic down_now = (pwr_state == main_synth_pkg::PWR_DOWN);

   // timeout code 2 forces full current
   wire logic force_full = (main_acq_timeout == `TOC_PIN_FORCE);

   wire logic [1:0] gain_eff = force_full  ? `GAIN_FORCED :
                               engaged_now ? main_acq_pump_gain : main_pump_gain;

   wire logic [4:0] ma_eff = (gain_eff == 2'h0) ? `GAIN_MA_0 :
                             (gain_eff == 2'h1) ? `GAIN_MA_1 :
                             (gain_eff == 2'h2) ? `GAIN_MA_2 : `GAIN_MA_3;

   // pin function by timeout code
   // pin follows the state, so it drops in the same cycle as acq_engaged
   wire logic pin_oe_eff  = (main_acq_timeout != `TOC_PIN_FLOAT) || engaged_now;
   wire logic pin_out_eff = (main_acq_timeout == `TOC_PIN_HIGH) || engaged_now;

   // slip reduction only acts in fractional mode while acquisition runs
   wire logic [1:0] slip_eff = (frac_mode && engaged_now) ? main_slip_reduction : 2'h0;

   // assembled next outputs
   main_synth_pkg::divider_ctrl_t next_divider;
   main_synth_pkg::pump_ctrl_t    next_pump;

   assign next_divider.modulus_large    = main_modulus_select;
   assign next_divider.frac_mode        = frac_mode;
   assign next_divider.swallow_count    = swallow_eff;
   assign next_divider.mid_count        = mid_eff;
   assign next_divider.high_count       = high_eff;
   assign next_divider.int_division     = main_int_division;
   assign next_divider.frac_numerator   = main_frac_numerator;
   assign next_divider.frac_denominator = den_eff;
   assign next_divider.n_total          = n_total_eff;
   assign next_divider.r_total          = r_total_eff;

   assign next_pump.gain       = gain_eff;
   assign next_pump.current_ma = ma_eff;
   assign next_pump.polarity   = main_detector_polarity;
   assign next_pump.tristate   = down_now;

   // every output leaves from a flop; settings are safe defaults in reset
   always_ff @(posedge core_clk) begin
      if (rst) begin
         divider            <= '0;
         pump               <= '0;
         counter_reset_hold <= 1'b0;
         synth_power_down   <= 1'b0;
         ref_input_float    <= 1'b0;
         acq_engaged        <= 1'b0;
         slip_factor        <= 2'h0;
         frac_comp_enable   <= 1'b0;
         acq_pin_out        <= 1'b0;
         acq_pin_oe         <= 1'b0;
      end else begin
         divider            <= next_divider;
         pump               <= next_pump;
         counter_reset_hold <= main_counter_reset;
         synth_power_down   <= down_now;
         ref_input_float    <= down_now & auxpd_stable;
         acq_engaged        <= engaged_now;
         slip_factor        <= slip_eff;
         frac_comp_enable   <= frac_compensation_enable;
         acq_pin_out        <= pin_out_eff;
         acq_pin_oe         <= pin_oe_eff;
      end
   end

endmodule

`default_nettype wire

// ==== sim/serial_host_model.sv ====
// host model: bit-bangs 24-bit control words on the three-wire link
// assumes the bench calls write_word for one word at a time
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
   // three-wire link
   output logic ser_clk,
   output logic ser_data,
   output logic latch_en
);
   // link clock stands low outside frames
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      latch_en = 1'b0;
   end
   task automatic write_word(input logic [23:0] w);
      #3;
      for (int i = 23; i >= 0; i--) begin
         ser_data = w[i];
         #40 ser_clk = 1'b1;
         #40 ser_clk = 1'b0;
      end
      ser_data = ~w[0]; // stale bit never looks valid
      #20 latch_en = 1'b1;
      #40 latch_en = 1'b0; // well over four core cycles
      #40;
   endtask
endmodule
`default_nettype wire

// ==== sim/synth_ctrl_assertions.sv ====
// checker on the ports of the main synth control block
// assumes it is bound onto main_synth_divider_control
`timescale 1ns/1ps
`default_nettype none
module synth_ctrl_checker (
   // clock and reset
   input wire logic                          core_clk,
   input wire logic                          rst,
   // watched signals
   input wire logic                          latch_en,
   input wire logic                          cmp_tick,
   input wire main_synth_pkg::divider_ctrl_t divider,
   input wire main_synth_pkg::pump_ctrl_t    pump,
   input wire logic                          synth_power_down,
   input wire logic                          ref_input_float,
   input wire logic                          acq_engaged,
   input wire logic [1:0]                    slip_factor,
   input wire logic                          acq_pin_out,
   input wire logic                          acq_pin_oe
);
   logic up_q;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (rst);
   // outputs need one edge after reset to settle
   always_ff @(posedge core_clk) up_q <= !rst;

   a_gain_current: assert property (up_q |-> pump.current_ma == (5'h01 << (pump.gain == 2'h0 ? 0 : pump.gain + 1)))
      else $error("pump current does not match gain code");
   a_pd_tristate: assert property (up_q |-> pump.tristate == synth_power_down)
      else $error("pump not tristated with power down");
   a_ref_float: assert property (ref_input_float |-> synth_power_down)
      else $error("reference floats while powered up");
   a_slip_gate: assert property (slip_factor != 2'h0 |-> acq_engaged && divider.frac_mode)
      else $error("slip reduction outside fractional acquisition");
   a_pin_engaged: assert property (acq_engaged |-> acq_pin_oe && acq_pin_out)
      else $error("acquisition pin not high while engaged");
   a_count_split: assert property (up_q |-> divider.swallow_count == divider.int_division[1:0]
      && divider.high_count == divider.int_division[12:4] && divider.mid_count ==
      (divider.modulus_large ? divider.int_division[3:2] : {1'b0, divider.int_division[2]}))
      else $error("counter split wrong");
   a_n_total: assert property (up_q |-> divider.n_total == (divider.frac_mode ? 21'(divider.int_division)
      : 21'(divider.int_division) * divider.frac_denominator + divider.frac_numerator))
      else $error("total division wrong");
   a_den_range: assert property (up_q |-> divider.frac_denominator inside {[8'h01:8'h80]})
      else $error("denominator out of range");
   a_engage_hold: assert property ((acq_engaged && !cmp_tick && !latch_en) [*6] |=> acq_engaged)
      else $error("acquisition dropped without comparison ticks");

   c_engaged: cover property ($rose(acq_engaged));
   c_powered_down: cover property ($rose(synth_power_down));
   c_slip: cover property (slip_factor != 2'h0);
endmodule
bind main_synth_divider_control synth_ctrl_checker chk (
   .core_clk(core_clk), .rst(rst), .latch_en(latch_en), .cmp_tick(cmp_tick),
   .divider(divider), .pump(pump), .synth_power_down(synth_power_down),
   .ref_input_float(ref_input_float), .acq_engaged(acq_engaged), .slip_factor(slip_factor),
   .acq_pin_out(acq_pin_out), .acq_pin_oe(acq_pin_oe)
);
`default_nettype wire

// ==== sim/test_main_synth_divider_control.sv ====
// self-checking bench for the main synth control block
// assumes the host model and the bound checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "main_synth_defines.svh"
module test_main_synth_divider_control;
   logic                          core_clk, rst, cmp_tick, pump_busy, aux_powered_down;
   wire logic                     ser_clk, ser_data, latch_en;
   main_synth_pkg::divider_ctrl_t divider;
   main_synth_pkg::pump_ctrl_t    pump;
   logic                          crh, spd, rif, eng_o, fce, pin_o, pin_oe;
   logic [1:0]                    slip;
   logic [15:0]                   lfsr_q;
   int gain = 0, pol = 0, modl = 0, crst = 0, rdiv = 0, den = 0, pd = 0, pdx = 0, nint = 0, num = 0;
   int csr = 0, om = 0, acqg = 0, toc = 0, comp_en = 0, pdm = 0, eng = 0, err_count = 0, checks_done = 0;

   main_synth_divider_control DUT (
      .core_clk(core_clk), .rst(rst), .ser_clk(ser_clk), .ser_data(ser_data), .latch_en(latch_en),
      .cmp_tick(cmp_tick), .pump_busy(pump_busy), .aux_powered_down(aux_powered_down),
      .divider(divider), .pump(pump), .counter_reset_hold(crh), .synth_power_down(spd),
      .ref_input_float(rif), .acq_engaged(eng_o), .slip_factor(slip), .frac_comp_enable(fce),
      .acq_pin_out(pin_o), .acq_pin_oe(pin_oe));
   serial_host_model host (.ser_clk(ser_clk), .ser_data(ser_data), .latch_en(latch_en));

   // core clock, 4 ns
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_count++;
         $display("BAD %s expected %0h seen %0h", name, exp, seen);
      end
   endtask

   // pack the model state into one word and send it
   task automatic put(input int a);
      logic [23:0] w;
      case (a)
         3: w = {crst[0], modl[0], pol[0], gain[1:0], rdiv[8:0], den[6:0], `ADDR_REF_WORD};
         4: w = {pd[0], nint[12:0], num[6:0], `ADDR_N_WORD};
         5: w = {1'b0, csr[1:0], om[1:0], acqg[1:0], toc[13:0], `ADDR_ACQ_WORD};
         default: w = {7'h00, comp_en[0], 7'h00, pdm[0], 5'h00, `ADDR_CFG_WORD};
      endcase
      host.write_word(w);
      if (a == 4) begin
         eng = (toc >= 4);
         pdx = pd;
      end
      if (a == 5 && toc < 4)
         eng = 0;
      repeat (4) @(negedge core_clk);
   endtask

   task automatic ticks(input int n);
      repeat (n) begin
         cmp_tick = 1'b1;
         repeat (4) @(negedge core_clk);
         cmp_tick = 1'b0;
         repeat (4) @(negedge core_clk);
      end
   endtask

   // expected outputs worked out from the model state
   task automatic check_all();
      int d, g, ma;
      logic [1:0] m;
      d = (den == 0) ? 128 : den;
      g = (toc == 2) ? 3 : (eng ? acqg : gain);
      ma = (g == 0) ? 1 : (1 << (g + 1));
      m = modl[0] ? nint[3:2] : {1'b0, nint[2]};
      chk("n_total", divider.n_total, (om == 1) ? nint : nint * d + num);
      chk("r_total", divider.r_total, (om == 1) ? rdiv : rdiv * d);
      chk("den", divider.frac_denominator, d);
      chk("split", {divider.high_count, divider.mid_count, divider.swallow_count}, {nint[12:4], m, nint[1:0]});
      chk("modulus", divider.modulus_large, modl);
      chk("mode", divider.frac_mode, om == 1);
      chk("gain", pump.gain, g);
      chk("current", pump.current_ma, ma);
      chk("polarity", pump.polarity, pol);
      chk("power", {spd, pump.tristate, rif}, {pdx[0], pdx[0], pdx[0] & aux_powered_down});
      chk("cnt_reset", crh, crst);
      chk("engaged", eng_o, eng);
      chk("slip", slip, (om == 1 && eng) ? csr : 0);
      chk("comp_en", fce, comp_en);
      chk("pin", {pin_oe, pin_o}, toc == 0 ? 0 : toc == 3 ? 3 : toc >= 4 ? 2 + eng : 2);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // a full run needs about 60 us
   initial begin
      #200000;
      err_count++;
      final_report();
   end

   initial begin
      rst = 1'b1;
      cmp_tick = 1'b0;
      pump_busy = 1'b0;
      aux_powered_down = 1'b0;
      lfsr_q = 16'h0036;
      repeat (8) @(negedge core_clk);
      rst = 1'b0;
      repeat (2) @(negedge core_clk);
      check_all();
      // every gain code, random divisors; integer part kept in range
      for (int i = 0; i < 4; i++) begin
         lfsr_q = lfsr(lfsr_q);
         gain = i;
         modl = lfsr_q[0];
         pol = lfsr_q[1];
         crst = (i == 3);
         rdiv = 1 + lfsr_q[8:0] % 511;
         den = lfsr_q[15:9];
         nint = modl ? 80 + lfsr_q % 8112 : 40 + lfsr_q % 4056;
         num = lfsr_q[6:0];
         put(3);
         put(4);
         check_all();
      end
      // fractional run with compensation and slip reduction
      // integer part stays in the normal range here
      om = 1;
      comp_en = 1;
      csr = 2;
      acqg = 3;
      toc = 5;
      den = 40;
      put(3);
      put(6);
      put(5);
      put(4);
      check_all();
      ticks(3);
      // new N word restarts the count
      put(4);
      ticks(4);
      check_all();
      ticks(1);
      eng = 0;
      check_all();
      // re-engage; a low timeout code drops acquisition, then sets the pin function
      put(4);
      for (int t = 0; t < 4; t++) begin
         toc = t;
         put(5);
         check_all();
         put(4);
         check_all();
      end
      // async power down; writes still land
      aux_powered_down = 1'b1;
      pd = 1;
      put(4);
      gain = 1;
      put(3);
      check_all();
      // one N word powers back up
      pd = 0;
      put(4);
      check_all();
      // sync mode waits for the pump pulse
      pdm = 1;
      put(6);
      pump_busy = 1'b1;
      pd = 1;
      put(4);
      pdx = 0;
      check_all();
      pump_busy = 1'b0;
      repeat (8) @(negedge core_clk);
      pdx = 1;
      check_all();
      final_report();
   end
endmodule
`default_nettype wire
